// [rtl/ars_cs_capture.sv]
// captures the leading channel status bits of one sub-frame stream
// assumes bit_idx is the frame number inside the block
module ars_cs_capture #(
  parameter int W     = 32,
  parameter int IDX_W = 5
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // received bits
  input  wire logic             bit_we,
  input  wire logic [IDX_W-1:0] bit_idx,
  input  wire logic             bit_in,
  // collected word
  output logic      [W-1:0]     word
);
  import ars_pkg::*;

  typedef struct packed {
    logic [W-1:0] bits;
  } ars_cap_state_t;

  ars_cap_state_t st;
  ars_cap_state_t next_st;

  always_comb begin
    next_st = st;
    if (bit_we) begin
      next_st.bits[bit_idx] = bit_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.bits;

endmodule // ars_cs_capture

// [rtl/ars_pkg.sv]
// constants and types shared by the audio receiver status reporting block
// assumes clk is the recovered master clock, nominally 256 times the sample rate
package ars_pkg;

  // channel status block framing
  localparam logic [7:0]  ARS_LAST_FRAME    = 8'hbf;  // 192 frames per block
  localparam logic [7:0]  ARS_BLK_IND_END   = 8'h20;  // first four bytes = 32 frames
  localparam int          ARS_CS_BITS       = 32;
  localparam int          ARS_CS_IDX_W      = 5;

  // error clear: select high for more than this many master clock cycles
  localparam logic [3:0]  ARS_SEL_CLR_CYC   = 4'h8;

  // frequency measurement: three windows per block, first at frame 0
  localparam int          ARS_FREQ_REF_HZ   = 6144000;
  localparam logic [7:0]  ARS_WIN_FRAMES    = 8'h40;
  localparam int          ARS_WIN_N         = 64;
  localparam int          ARS_TOL_DIV       = 25;     // +/- 4 percent acceptance
  localparam int          ARS_REF_CNT_W     = 16;
  localparam int          ARS_NOM_96K       = ARS_FREQ_REF_HZ * ARS_WIN_N / 96000;
  localparam int          ARS_NOM_48K       = ARS_FREQ_REF_HZ * ARS_WIN_N / 48000;
  localparam int          ARS_NOM_44K       = ARS_FREQ_REF_HZ * ARS_WIN_N / 44100;
  localparam int          ARS_NOM_32K       = ARS_FREQ_REF_HZ * ARS_WIN_N / 32000;

  // channel status bit chosen for each parallel pin, per format
  localparam logic [4:0]  ARS_PRO_IDX [5]   = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08};
  localparam logic [4:0]  ARS_CON_IDX [5]   = '{5'h01, 5'h02, 5'h03, 5'h0f, 5'h18};

  // register map, word indexes decoded from haddr[3:2]
  localparam logic [1:0]  ARS_REG_CTRL      = 2'h0;
  localparam logic [1:0]  ARS_REG_STATUS    = 2'h1;
  localparam logic [1:0]  ARS_REG_CS_SF1    = 2'h2;
  localparam logic [1:0]  ARS_REG_CS_SF2    = 2'h3;
  localparam int          ARS_CTRL_I2S_BIT  = 0;
  localparam logic [31:0] ARS_CTRL_RESET    = 32'h0000_0000;
  localparam int          ARS_ST_ERR_LSB    = 0;
  localparam int          ARS_ST_FREQ_LSB   = 3;
  localparam int          ARS_ST_SEL_BIT    = 6;
  localparam int          ARS_ST_BLK_BIT    = 7;
  localparam int          ARS_ST_FLAG_BIT   = 8;

  typedef enum logic [2:0] {
    ARS_ERR_NONE    = 3'b000,
    ARS_ERR_PARITY  = 3'b001,
    ARS_ERR_BIPHASE = 3'b010,
    ARS_ERR_UNLOCK  = 3'b011
  } ars_err_t;

  typedef enum logic [2:0] {
    ARS_FREQ_NONE = 3'b000,
    ARS_FREQ_96K  = 3'b001,
    ARS_FREQ_48K  = 3'b010,
    ARS_FREQ_44K  = 3'b011,
    ARS_FREQ_32K  = 3'b100
  } ars_freq_t;

endpackage

// [rtl/ars_status_top.sv]
// status reporting of a digital audio receiver: serial C/U pins, block start,
// six shared pins for channel status or error and frequency codes, AHB-Lite regs
// assumes the decoder presents one strobe per sub-frame on clk (recovered master
// clock); sel and the shared channel/reference pin are asynchronous pins
//
// Behaviour
// [R1] channel status bit shifted out serially
// [R2] user bit shifted out serially
// [R3] I2S mode: serial pins change at fsync edge
// [R4] select high: shared pins show channel status
// [R5] choice low sub-frame 1, high sub-frame 2
// [R6] first pin inverted bit 0, format picks rest
// [R7] parallel status refreshed on block start rise
// [R8] select low: three pins carry frequency code
// [R9] far side gives reference clock long enough
// [R10] frequency code updated thrice per block
// [R11] compare reference against received rate, 6.144MHz
// [R12] shared input: choice or reference by select
// [R13] select low: other pins carry error code
// [R14] error code prioritized and held until clear
// [R15] select high over 8 cycles clears errors
// [R16] block start high 4 bytes, low 20
// [R17] error flag: parity, biphase or unlock
// [R18] master clock runs at 256 times rate
// [R19] own encodings and priorities for codes
// [R20] select synchronised and high cycles counted
module ars_status_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // decoder side, same clock
  input  wire logic        sf_valid,
  input  wire logic        sf_second,
  input  wire logic        sf_block_first,
  input  wire logic        cs_bit_in,
  input  wire logic        user_bit_in,
  input  wire logic        parity_err,
  input  wire logic        biphase_err,
  input  wire logic        pll_unlock,
  input  wire logic        frame_sync,
  // asynchronous pins
  input  wire logic        sel,
  input  wire logic        subframe_choice,
  // serial and flag pins
  output logic             cs_serial,
  output logic             user_serial,
  output logic             block_start_ind,
  output logic             sample_error_flag,
  // shared pins: channel status when sel high, error/frequency when low
  output logic             pro_consumer_flag_n,
  output logic             status_par_bit_a,
  output logic             status_par_bit_b,
  output logic             status_par_bit_c,
  output logic             status_par_bit_d,
  output logic             status_par_bit_e
);
  import ars_pkg::*;

  typedef struct packed {
    logic                     ready;
    logic                     dp_valid;
    logic                     dp_write;
    logic [1:0]               dp_idx;
    logic [31:0]              rdata;
    logic                     i2s_mode;
    logic [7:0]               frame;
    logic                     blk;
    logic                     fsync_prev;
    logic                     cs_hold;
    logic                     u_hold;
    logic                     cs_out;
    logic                     u_out;
    logic                     err_flag;
    ars_err_t                 err_code;
    logic [3:0]               clr_cnt;
    logic [ARS_REF_CNT_W-1:0] ref_cnt;
    logic                     win_ok;
    logic                     ref_prev;
    ars_freq_t                freq_code;
    logic [5:0]               cs_par;
    logic [5:0]               pins;
  } ars_top_state_t;

  ars_top_state_t st;
  ars_top_state_t next_st;

  logic [1:0]                 pin_sync;
  logic                       sel_s;
  logic                       shared_s;
  logic [ARS_CS_BITS-1:0]     cs_word_sf1;
  logic [ARS_CS_BITS-1:0]     cs_word_sf2;
  logic                       cap_we;
  logic                       cap_we_sf1;
  logic                       cap_we_sf2;

  // [R20] both pins pass two flip-flops before any logic reads them
  ars_sync #(
    .W        (2)
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({sel, subframe_choice}),
    .sync_out (pin_sync)
  );

  assign sel_s    = pin_sync[1];
  assign shared_s = pin_sync[0];

  // only the first 32 frames of a block hold the bits shown in parallel
  assign cap_we     = sf_valid && (next_st.frame < ARS_BLK_IND_END);
  assign cap_we_sf1 = cap_we && !sf_second;
  assign cap_we_sf2 = cap_we && sf_second;

  ars_cs_capture #(
    .W       (ARS_CS_BITS),
    .IDX_W   (ARS_CS_IDX_W)
  ) u_cap_sf1 (
    .clk     (clk),
    .rst     (rst),
    .bit_we  (cap_we_sf1),
    .bit_idx (next_st.frame[ARS_CS_IDX_W-1:0]),
    .bit_in  (cs_bit_in),
    .word    (cs_word_sf1)
  );

  ars_cs_capture #(
    .W       (ARS_CS_BITS),
    .IDX_W   (ARS_CS_IDX_W)
  ) u_cap_sf2 (
    .clk     (clk),
    .rst     (rst),
    .bit_we  (cap_we_sf2),
    .bit_idx (next_st.frame[ARS_CS_IDX_W-1:0]),
    .bit_in  (cs_bit_in),
    .word    (cs_word_sf2)
  );

  // window counts are classified with a tolerance band around each nominal rate
  function automatic logic in_band(input logic [ARS_REF_CNT_W-1:0] cnt, input int nom);
    int lo;
    int hi;
    lo = nom - nom / ARS_TOL_DIV;
    hi = nom + nom / ARS_TOL_DIV;
    return (int'(cnt) >= lo) && (int'(cnt) <= hi);
  endfunction

  function automatic ars_freq_t classify(input logic [ARS_REF_CNT_W-1:0] cnt);
    ars_freq_t code;
    code = ARS_FREQ_NONE;
    if (in_band(cnt, ARS_NOM_96K)) begin
      code = ARS_FREQ_96K;
    end else if (in_band(cnt, ARS_NOM_48K)) begin
      code = ARS_FREQ_48K;
    end else if (in_band(cnt, ARS_NOM_44K)) begin
      code = ARS_FREQ_44K;
    end else if (in_band(cnt, ARS_NOM_32K)) begin
      code = ARS_FREQ_32K;
    end
    return code;
  endfunction

  function automatic logic [5:0] cs_pins(input logic [ARS_CS_BITS-1:0] w);
    logic [5:0] p;
    p[0] = ~w[0];
    for (int i = 0; i < 5; i++) begin
      p[i+1] = w[0] ? w[ARS_PRO_IDX[i]] : w[ARS_CON_IDX[i]];
    end
    return p;
  endfunction

  always_comb begin
    logic       take;
    logic       blk_rise;
    logic       win_edge;
    logic       fs_edge;
    logic       err_clear;
    logic       ref_rise;
    ars_err_t   new_err;
    logic [1:0] ridx;
    take      = 1'b0;
    blk_rise  = 1'b0;
    win_edge  = 1'b0;
    fs_edge   = 1'b0;
    err_clear = 1'b0;
    ref_rise  = 1'b0;
    new_err   = ARS_ERR_NONE;
    ridx      = haddr[3:2];
    next_st   = st;

    // bus slave: zero wait states, always OKAY
    next_st.ready = 1'b1;
    if (st.dp_valid && st.dp_write && st.dp_idx == ARS_REG_CTRL) begin
      next_st.i2s_mode = hwdata[ARS_CTRL_I2S_BIT];
    end
    take = hsel && htrans[1] && hready;
    next_st.dp_valid = take && (haddr[31:4] == '0);
    next_st.dp_write = hwrite;
    next_st.dp_idx   = ridx;
    if (take && !hwrite) begin
      next_st.rdata = '0;
      if (haddr[31:4] == '0) begin
        unique case (ridx)
          ARS_REG_CTRL: begin
            next_st.rdata[ARS_CTRL_I2S_BIT] = st.i2s_mode;
            if (st.dp_valid && st.dp_write && st.dp_idx == ARS_REG_CTRL) begin
              next_st.rdata[ARS_CTRL_I2S_BIT] = hwdata[ARS_CTRL_I2S_BIT];
            end
          end
          ARS_REG_STATUS: begin
            next_st.rdata[ARS_ST_ERR_LSB +: 3]  = st.err_code;
            next_st.rdata[ARS_ST_FREQ_LSB +: 3] = st.freq_code;
            next_st.rdata[ARS_ST_SEL_BIT]       = sel_s;
            next_st.rdata[ARS_ST_BLK_BIT]       = st.blk;
            next_st.rdata[ARS_ST_FLAG_BIT]      = st.err_flag;
          end
          ARS_REG_CS_SF1: next_st.rdata = cs_word_sf1;
          ARS_REG_CS_SF2: next_st.rdata = cs_word_sf2;
        endcase
      end
    end

    // frame position; clk is taken as 256 x fs, so frames are sub-frame 1 strobes [R18]
    if (sf_valid && !sf_second) begin
      if (sf_block_first || st.frame == ARS_LAST_FRAME) begin
        next_st.frame = '0;
      end else begin
        next_st.frame = st.frame + 8'h01;
      end
      next_st.blk = (next_st.frame < ARS_BLK_IND_END);                  // [R16]
      blk_rise    = next_st.blk && !st.blk;
      win_edge    = (next_st.frame[5:0] == '0) && (next_st.frame < ARS_LAST_FRAME);
    end

    // [R7] [R5] latch the finished block for the chosen sub-frame
    if (blk_rise) begin
      next_st.cs_par = shared_s ? cs_pins(cs_word_sf2) : cs_pins(cs_word_sf1);  // [R6]
    end

    // serial channel status and user bits
    if (sf_valid) begin
      next_st.cs_hold = cs_bit_in;
      next_st.u_hold  = user_bit_in;
    end
    next_st.fsync_prev = frame_sync;
    fs_edge = frame_sync != st.fsync_prev;
    if (st.i2s_mode) begin
      // i2s: bits follow the word clock so they line up with the audio word [R3]
      if (fs_edge) begin
        next_st.cs_out = st.cs_hold;
        next_st.u_out  = st.u_hold;
      end
    end else if (sf_valid) begin
      next_st.cs_out = cs_bit_in;                                       // [R1]
      next_st.u_out  = user_bit_in;                                     // [R2]
    end

    // [R17] per-sample error flag, unlock forces it at once
    if (sf_valid) begin
      next_st.err_flag = parity_err || biphase_err || pll_unlock;
    end else if (pll_unlock) begin
      next_st.err_flag = 1'b1;
    end

    // [R19] unlock outranks biphase, biphase outranks parity
    if (pll_unlock) begin
      new_err = ARS_ERR_UNLOCK;
    end else if (sf_valid && biphase_err) begin
      new_err = ARS_ERR_BIPHASE;
    end else if (sf_valid && parity_err) begin
      new_err = ARS_ERR_PARITY;
    end

    // [R20] [R15] count consecutive high select cycles, saturating
    if (!sel_s) begin
      next_st.clr_cnt = '0;
    end else if (st.clr_cnt != ARS_SEL_CLR_CYC) begin
      next_st.clr_cnt = st.clr_cnt + 4'h1;
    end
    err_clear = sel_s && (st.clr_cnt == ARS_SEL_CLR_CYC);

    // [R14] held code only rises; an error in the clearing cycle survives
    if (err_clear) begin
      next_st.err_code = new_err;
    end else if (new_err > st.err_code) begin
      next_st.err_code = new_err;
    end

    // [R12] [R11] reference edges counted only while the pin is the reference
    next_st.ref_prev = shared_s;
    ref_rise = shared_s && !st.ref_prev && !sel_s;
    if (ref_rise && st.ref_cnt != '1) begin
      next_st.ref_cnt = st.ref_cnt + 1'b1;
    end
    if (sel_s) begin
      next_st.win_ok = 1'b0;
    end
    // [R10] evaluate at frames 0, 64 and 128; a window disturbed by select reports none
    if (win_edge) begin
      next_st.freq_code = st.win_ok ? classify(st.ref_cnt) : ARS_FREQ_NONE;
      next_st.ref_cnt   = '0;
      next_st.win_ok    = !sel_s;
    end

    // [R4] [R8] [R13] shared pin contents
    if (sel_s) begin
      next_st.pins = st.cs_par;
    end else begin
      next_st.pins = {st.freq_code, st.err_code};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st           <= '0;
      st.i2s_mode  <= ARS_CTRL_RESET[ARS_CTRL_I2S_BIT];
      st.err_code  <= ARS_ERR_NONE;
      st.freq_code <= ARS_FREQ_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout           = st.ready;
  assign hresp               = 1'b0 & st.ready;
  assign hrdata              = st.rdata;
  assign cs_serial           = st.cs_out;
  assign user_serial         = st.u_out;
  assign block_start_ind     = st.blk;
  assign sample_error_flag   = st.err_flag;
  assign pro_consumer_flag_n = st.pins[0];
  assign status_par_bit_a    = st.pins[1];
  assign status_par_bit_b    = st.pins[2];
  assign status_par_bit_c    = st.pins[3];
  assign status_par_bit_d    = st.pins[4];
  assign status_par_bit_e    = st.pins[5];

endmodule // ars_status_top

// [rtl/ars_sync.sv]
// two flip-flop synchroniser for asynchronous pin levels
// assumes inputs are quasi-static levels or clocks slower than half of clk
module ars_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import ars_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ars_sync_state_t;

  ars_sync_state_t st;
  ars_sync_state_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule // ars_sync

// [verif/ars_far_model.sv]
// far side: drives the shared choice / reference pin
// assumes ref_run is raised only while the bench holds sel low
module ars_far_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench control
  input  wire logic ref_run,
  input  wire logic choice_lvl,
  // shared pin
  output logic      subframe_choice
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  // a four-cycle period keeps the reference well below half of clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 2'h0;
      subframe_choice <= 1'b0;
    end else if (ref_run) begin
      ph <= ph + 2'h1;
      subframe_choice <= ph[1];
    end else begin
      ph <= 2'h0;
      subframe_choice <= choice_lvl;
    end
  end
endmodule // ars_far_model

// [verif/ars_status_assertions.sv]
// concurrent checks on the ports of ars_status_top
// assumes one clock domain; bound from the bench top file
module ars_status_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // decoder side
  input wire logic sf_valid,
  input wire logic sf_second,
  input wire logic sf_block_first,
  input wire logic parity_err,
  input wire logic biphase_err,
  input wire logic pll_unlock,
  input wire logic frame_sync,
  input wire logic sel,
  // outputs
  input wire logic cs_serial,
  input wire logic user_serial,
  input wire logic block_start_ind,
  input wire logic sample_error_flag,
  input wire logic pro_consumer_flag_n,
  input wire logic status_par_bit_a,
  input wire logic status_par_bit_b,
  input wire logic status_par_bit_c,
  input wire logic status_par_bit_d,
  input wire logic status_par_bit_e
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pins;
  assign pins = {status_par_bit_e, status_par_bit_d, status_par_bit_c,
                 status_par_bit_b, status_par_bit_a, pro_consumer_flag_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // six samples cover the sync stages plus the output register
  sequence s_sel_hi; sel [*6]; endsequence
  sequence s_sel_lo; !sel [*6]; endsequence
  property p_cs_ser;
    !$stable(cs_serial) |-> $past(sf_valid) || ($past(frame_sync) != $past(frame_sync, 3));
  endproperty
  a_cs_ser: assert property (p_cs_ser) else $error("status bit moved without strobe");
  property p_u_ser;
    !$stable(user_serial) |-> $past(sf_valid) || ($past(frame_sync) != $past(frame_sync, 3));
  endproperty
  a_u_ser: assert property (p_u_ser) else $error("user bit moved without strobe");
  property p_flag;
    sf_valid && (parity_err || biphase_err) |=> sample_error_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("error flag missed");
  property p_unlock;
    pll_unlock [*3] |-> sample_error_flag;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock flag missed");
  property p_blk;
    sf_valid && !sf_second && sf_block_first |=> block_start_ind;
  endproperty
  a_blk: assert property (p_blk) else $error("block start not raised");
  property p_pins;
    s_sel_hi ##0 !$stable(pins) |-> $past(block_start_ind) && !$past(block_start_ind, 4);
  endproperty
  a_pins: assert property (p_pins) else $error("status pins moved off block start");
  property p_err;
    s_sel_lo ##0 !$stable(pins[2:0]) |-> pins[2:0] > $past(pins[2:0]);
  endproperty
  a_err: assert property (p_err) else $error("error code fell without clear");
  property p_freq;
    s_sel_lo ##0 !$stable(pins[5:3]) |-> $past(sf_valid, 2) || $past(sf_valid, 3);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency code moved off frame");
  // hreadyout is still low in the cycle after the last reset edge
  property p_bus;
    !$past(rst) |-> hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus slave not ready or not okay");
endmodule // ars_status_assertions

// [verif/ars_status_top_tb.sv]
// self-checking bench for the audio receiver status block
// assumes the far model drives the shared pin; checker bound below
module ars_status_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ars_pkg::*;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sf_valid, sf_second, sf_block_first, cs_bit_in, user_bit_in;
  logic        parity_err, biphase_err, pll_unlock, frame_sync, sel, subframe_choice;
  logic        cs_serial, user_serial, block_start_ind, sample_error_flag;
  logic        pro_consumer_flag_n, status_par_bit_a, status_par_bit_b;
  logic        status_par_bit_c, status_par_bit_d, status_par_bit_e;
  logic        ref_run, choice_lvl, pe, be;
  logic [5:0]  pins;
  int          error_cnt, comparisons;
  localparam logic [31:0] W1 = 32'h0100000a;  // consumer word
  localparam logic [31:0] W2 = 32'h00000115;  // professional word
  assign pins = {status_par_bit_e, status_par_bit_d, status_par_bit_c,
                 status_par_bit_b, status_par_bit_a, pro_consumer_flag_n};
  ars_status_top uut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sf_valid, .sf_second,
    .sf_block_first, .cs_bit_in, .user_bit_in, .parity_err, .biphase_err, .pll_unlock,
    .frame_sync, .sel, .subframe_choice, .cs_serial, .user_serial, .block_start_ind,
    .sample_error_flag, .pro_consumer_flag_n, .status_par_bit_a, .status_par_bit_b,
    .status_par_bit_c, .status_par_bit_d, .status_par_bit_e);
  ars_far_model u_far (.clk, .rst, .ref_run, .choice_lvl, .subframe_choice);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // sub-frame 1 then 2 on back-to-back strobes, then idle cycles
  task automatic frame(input logic c1, c2, u, first, input int len);
    @(posedge clk);
    sf_valid <= 1'b1;
    sf_second <= 1'b0;
    sf_block_first <= first;
    cs_bit_in <= c1;
    user_bit_in <= u;
    parity_err <= pe;
    biphase_err <= be;
    @(posedge clk);
    sf_second <= 1'b1;
    sf_block_first <= 1'b0;
    cs_bit_in <= c2;
    parity_err <= 1'b0;
    biphase_err <= 1'b0;
    @(posedge clk);
    sf_valid <= 1'b0;
    repeat (len) @(posedge clk);
  endtask
  task automatic send_block(input logic [31:0] w1, w2);
    for (int n = 0; n < 33; n++) begin
      frame(w1[n % 32], w2[n % 32], 1'b0, n == 0, 4);
      chk(block_start_ind, n < 32);
    end
  endtask
  // pin order {e,d,c,b,a,n}
  function automatic logic [5:0] exp_cs(input logic [31:0] w);
    if (w[0]) return {w[8], w[4], w[3], w[2], w[1], 1'b0};
    return {w[24], w[15], w[3], w[2], w[1], 1'b1};
  endfunction
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t run took too long", $time);
    print_verdict();
  end
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, sf_valid, sf_second, sf_block_first} = '0;
    {cs_bit_in, user_bit_in, parity_err, biphase_err, pll_unlock, frame_sync} = '0;
    {sel, ref_run, choice_lvl, pe, be, error_cnt, comparisons} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(32'h0, 1'b0, 32'h0);
    chk(q, ARS_CTRL_RESET);
    ahb(32'h40, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    pe = 1'b1;
    frame(1'b1, 1'b1, 1'b1, 1'b1, 8);
    chk(cs_serial, 1'b1);
    chk(user_serial, 1'b1);
    chk(pins[2:0], ARS_ERR_PARITY);
    pe = 1'b0;
    be = 1'b1;
    frame(1'b0, 1'b0, 1'b0, 1'b0, 8);
    chk(pins[2:0], ARS_ERR_BIPHASE);
    be = 1'b0;
    pe = 1'b1;
    frame(1'b1, 1'b0, 1'b0, 1'b0, 8);
    pe = 1'b0;
    chk(pins[2:0], ARS_ERR_BIPHASE);
    chk(cs_serial, 1'b0);
    pll_unlock <= 1'b1;
    repeat (4) @(posedge clk);
    chk(sample_error_flag, 1'b1);
    pll_unlock <= 1'b0;
    repeat (4) @(posedge clk);
    chk(pins[2:0], ARS_ERR_UNLOCK);
    // exactly eight cycles high is not yet a clear
    sel <= 1'b1;
    repeat (8) @(posedge clk);
    sel <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pins[2:0], ARS_ERR_UNLOCK);
    sel <= 1'b1;
    repeat (12) @(posedge clk);
    ahb(32'h4, 1'b0, 32'h0);
    chk(q[2:0], ARS_ERR_NONE);
    $display("test errors done");
    send_block(W1, W2);
    ahb(32'h8, 1'b0, 32'h0);
    chk(q, W1);
    ahb(32'hc, 1'b0, 32'h0);
    chk(q, W2);
    frame(W1[0], W2[0], 1'b0, 1'b1, 8);
    chk(pins, exp_cs(W1));
    choice_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pins, exp_cs(W1));
    send_block(W1, W2);
    // block start must fall and rise again before the new choice is shown
    frame(W1[0], W2[0], 1'b0, 1'b1, 8);
    chk(pins, exp_cs(W2));
    $display("test channel status done");
    sel <= 1'b0;
    ref_run <= 1'b1;
    repeat (6) @(posedge clk);
    for (int n = 0; n < 64; n++) frame(1'b0, 1'b0, 1'b0, n == 0, 253);
    chk(pins[5:3], ARS_FREQ_NONE);
    frame(1'b0, 1'b0, 1'b0, 1'b0, 253);
    chk(pins[5:3], ARS_FREQ_96K);
    ahb(32'h4, 1'b0, 32'h0);
    chk(q[5:3], ARS_FREQ_96K);
    $display("test frequency done");
    ref_run <= 1'b0;
    ahb(32'h0, 1'b1, 32'h1);
    ahb(32'h0, 1'b0, 32'h0);
    chk(q, 32'h1);
    frame(1'b1, 1'b1, 1'b1, 1'b0, 4);
    chk(cs_serial, 1'b0);
    frame_sync <= 1'b1;
    repeat (3) @(posedge clk);
    chk(cs_serial, 1'b1);
    chk(user_serial, 1'b1);
    $display("test i2s done");
    print_verdict();
  end
endmodule // ars_status_top_tb
bind ars_status_top ars_status_assertions u_chk (.clk, .rst, .hreadyout, .hresp,
  .sf_valid, .sf_second, .sf_block_first, .parity_err, .biphase_err, .pll_unlock,
  .frame_sync, .sel, .cs_serial, .user_serial, .block_start_ind, .sample_error_flag,
  .pro_consumer_flag_n, .status_par_bit_a, .status_par_bit_b, .status_par_bit_c,
  .status_par_bit_d, .status_par_bit_e);
